// ---- shared/sedb_defs.vh ----
// Constants for the stretched external data bus sequencer
// Behaviour
// - Stretch code sets transfer length: 000 gives 2 machine cycles, each step adds one.
// - After reset the stretch selection is 001, three machine cycles.
// - Stretch interval is 4 oscillator periods per code step; strobe stays low that long, or 2 periods at code 000.
// - Address-latch strobe high 1.5 periods unstretched, 2 periods stretched.
// - Low address valid 0.5 period before latch strobe falls unstretched, 1 period stretched.
// - Writes hold low address after latch strobe falls: 0.5 or 1 period.
// - Read/write strobe falls 0.5 or 1 period after latch strobe falls.
// - High address valid 1.5 or 2.5 periods before read/write strobe falls.
// - Latch strobe rises no sooner than 4.5 periods after strobe rises, or 5.5 periods stretched.
// - Write data held after write strobe rises: 1 period, or 2 stretched.
// - Write data driven no later than the write strobe falls.
// - Low address driven strongly until latch strobe falls, then weakly held on reads.
`ifndef SEDB_DEFS_VH
`define SEDB_DEFS_VH

// ----------------------------------------
// Clock relations
// ----------------------------------------
`define SEDB_CORE_PERIOD_NS 50
`define SEDB_OSC_PERIOD_NS 100
`define SEDB_HALF_OSC_CYC ((`SEDB_OSC_PERIOD_NS / 2) / `SEDB_CORE_PERIOD_NS)

// ----------------------------------------
// Stretch selection
// ----------------------------------------
`define SEDB_STRETCH_RESET 3'h1
`define SEDB_HALVES_PER_MC 8
`define SEDB_BASE_MC 2
`define SEDB_INTERVAL_OSC_PER_STEP 4

// ----------------------------------------
// Phase points in half oscillator periods
// ----------------------------------------
`define SEDB_HI_START 1
`define SEDB_LO_START 2
`define SEDB_ALE_END_UNSTR 3
`define SEDB_ALE_END_STR 4
`define SEDB_STROBE_START_UNSTR 4
`define SEDB_STROBE_START_STR 6
`define SEDB_STROBE_LEN_UNSTR 4
`define SEDB_WHOLD_UNSTR 2
`define SEDB_WHOLD_STR 4
`define SEDB_READ_SYNC_LAG 2

`endif

// ---- verilog/sedb_sync.v ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sedb_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rstn,
  // Data
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] stage1;

  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage1 <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

// ---- verilog/sedb_timing.v ----
// Phase points of one transfer from the stretch code
`timescale 1ns/1ps
`include "sedb_defs.vh"
module sedb_timing #(
  parameter CW = 8,
  parameter [CW-1:0] HALF = `SEDB_HALF_OSC_CYC
) (
  // Stretch code
  input wire [2:0] i_code,
  // Phase points in core cycles
  output wire o_stretched,
  output wire [CW-1:0] o_hi_start,
  output wire [CW-1:0] o_lo_start,
  output wire [CW-1:0] o_ale_end,
  output wire [CW-1:0] o_strobe_start,
  output wire [CW-1:0] o_strobe_end,
  output wire [CW-1:0] o_wdata_end,
  output wire [CW-1:0] o_total
);

  wire [CW-1:0] code_w;
  wire [CW-1:0] strobe_len;
  wire [31:0] hi_full;
  wire [31:0] lo_full;
  wire [31:0] ale_full;
  wire [31:0] ss_full;
  wire [31:0] len_full;
  wire [31:0] we_full;
  wire [31:0] tot_full;

  assign code_w = {{(CW-3){1'b0}}, i_code};
  assign o_stretched = (i_code != 3'h0);
  // Products at full width, cut to counter width
  assign hi_full = HALF * `SEDB_HI_START;
  assign o_hi_start = hi_full[CW-1:0];
  // Address shown 0.5 or 1 period before latch strobe falls
  assign lo_full = HALF * `SEDB_LO_START;
  assign o_lo_start = lo_full[CW-1:0];
  assign ale_full = o_stretched ? HALF * `SEDB_ALE_END_STR :
                    HALF * `SEDB_ALE_END_UNSTR;
  assign o_ale_end = ale_full[CW-1:0];
  assign ss_full = o_stretched ? HALF * `SEDB_STROBE_START_STR :
                   HALF * `SEDB_STROBE_START_UNSTR;
  assign o_strobe_start = ss_full[CW-1:0];
  // Interval is 4 oscillator periods (8 halves) per step
  assign len_full = o_stretched ? HALF * (code_w * (2 * `SEDB_INTERVAL_OSC_PER_STEP)) :
                    HALF * `SEDB_STROBE_LEN_UNSTR;
  assign strobe_len = len_full[CW-1:0];
  assign o_strobe_end = o_strobe_start + strobe_len;
  assign we_full = o_strobe_end + (o_stretched ? HALF * `SEDB_WHOLD_STR :
                   HALF * `SEDB_WHOLD_UNSTR);
  assign o_wdata_end = we_full[CW-1:0];
  assign tot_full = HALF * ((code_w + `SEDB_BASE_MC) * `SEDB_HALVES_PER_MC);
  assign o_total = tot_full[CW-1:0];

endmodule

// ---- verilog/sedb_bus.v ----
// External data transfer sequencer with stretchable cycles
`timescale 1ns/1ps
`include "sedb_defs.vh"
module sedb_bus #(
  parameter CW = 8
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rstn,
  // Stretch selection
  input wire i_stretch_load,
  input wire i_stretch_sel_bit2,
  input wire i_stretch_sel_bit1,
  input wire i_stretch_sel_bit0,
  // Transfer request
  input wire i_req,
  input wire i_write,
  input wire [15:0] i_addr,
  input wire [7:0] i_wdata,
  // Transfer status
  output reg o_ready,
  output reg o_done,
  output reg [7:0] o_rdata,
  output reg [2:0] o_stretch_code,
  // External pins
  input wire [7:0] i_ad_in,
  output reg [7:0] o_ad_out,
  output reg o_ad_oe_n,
  output reg o_ad_weak,
  output reg [7:0] o_addr_hi,
  output reg o_ale,
  output reg o_rd_n,
  output reg o_wr_n
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg state;
  reg [CW-1:0] cnt;
  reg [2:0] code;
  reg [2:0] xfer_code;
  reg xfer_wr;
  reg [15:0] xfer_addr;
  reg [7:0] xfer_data;

  wire [7:0] ad_sync;
  wire stretched;
  wire [CW-1:0] hi_start;
  wire [CW-1:0] lo_start;
  wire [CW-1:0] ale_end;
  wire [CW-1:0] strobe_start;
  wire [CW-1:0] strobe_end;
  wire [CW-1:0] wdata_end;
  wire [CW-1:0] total;
  wire [CW-1:0] capture_at;
  wire [31:0] capture_full;

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  sedb_sync #(
    .WIDTH(8)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_async(i_ad_in),
    .o_sync(ad_sync)
  );

  // ----------------------------------------
  // Phase points
  // ----------------------------------------
  sedb_timing #(
    .CW(CW)
  ) u_timing (
    .i_code(xfer_code),
    .o_stretched(stretched),
    .o_hi_start(hi_start),
    .o_lo_start(lo_start),
    .o_ale_end(ale_end),
    .o_strobe_start(strobe_start),
    .o_strobe_end(strobe_end),
    .o_wdata_end(wdata_end),
    .o_total(total)
  );

  assign capture_full = strobe_end + `SEDB_READ_SYNC_LAG;
  assign capture_at = capture_full[CW-1:0];

  // ----------------------------------------
  // Stretch selection
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      code <= `SEDB_STRETCH_RESET;
      o_stretch_code <= `SEDB_STRETCH_RESET;
    end else begin
      if (i_stretch_load) begin
        code <= {i_stretch_sel_bit2, i_stretch_sel_bit1, i_stretch_sel_bit0};
        o_stretch_code <= {i_stretch_sel_bit2, i_stretch_sel_bit1, i_stretch_sel_bit0};
      end
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      cnt <= {CW{1'b0}};
      xfer_code <= `SEDB_STRETCH_RESET;
      xfer_wr <= 1'b0;
      xfer_addr <= 16'h0000;
      xfer_data <= 8'h00;
      o_ready <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      o_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          o_ready <= 1'b1;
          cnt <= {CW{1'b0}};
          if (i_req && o_ready) begin
            state <= ST_RUN;
            o_ready <= 1'b0;
            xfer_code <= code;
            xfer_wr <= i_write;
            xfer_addr <= i_addr;
            xfer_data <= i_wdata;
          end
        end
        ST_RUN: begin
          cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
          // Pin value at strobe rise, seen after the synchroniser
          if (!xfer_wr && cnt == capture_at) begin
            o_rdata <= ad_sync;
          end
          if (cnt == total - {{(CW-1){1'b0}}, 1'b1}) begin
            state <= ST_IDLE;
            o_done <= 1'b1;
            o_ready <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ale <= 1'b0;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_ad_out <= 8'h00;
      o_ad_oe_n <= 1'b1;
      o_ad_weak <= 1'b0;
      o_addr_hi <= 8'h00;
    end else if (state == ST_RUN) begin
      // Latch strobe high for 1.5 or 2 periods
      o_ale <= (cnt < ale_end);
      // High address stays from its start to the end of the transfer
      if (cnt >= hi_start) begin
        o_addr_hi <= xfer_addr[15:8];
      end
      // Strobe low from strobe start for the interval, or for 2 periods at code 000
      if (cnt >= strobe_start && cnt < strobe_end) begin
        o_rd_n <= xfer_wr;
        o_wr_n <= ~xfer_wr;
      end else begin
        o_rd_n <= 1'b1;
        o_wr_n <= 1'b1;
      end
      if (cnt >= lo_start && cnt < ale_end) begin
        o_ad_out <= xfer_addr[7:0];
        o_ad_oe_n <= 1'b0;
        o_ad_weak <= 1'b0;
      end else if (xfer_wr && cnt >= ale_end && cnt < strobe_start) begin
        o_ad_out <= xfer_addr[7:0];
        o_ad_oe_n <= 1'b0;
        o_ad_weak <= 1'b0;
      end else if (xfer_wr && cnt >= strobe_start && cnt < wdata_end) begin
        o_ad_out <= xfer_data;
        o_ad_oe_n <= 1'b0;
        o_ad_weak <= 1'b0;
      end else if (!xfer_wr && cnt >= ale_end && cnt < strobe_start) begin
        o_ad_oe_n <= 1'b1;
        o_ad_weak <= 1'b1;
      end else begin
        o_ad_oe_n <= 1'b1;
        o_ad_weak <= 1'b0;
      end
    end else begin
      o_ale <= 1'b0;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_ad_oe_n <= 1'b1;
      o_ad_weak <= 1'b0;
    end
  end

endmodule

// ---- tb/sedb_properties.sv ----
// Timing checker for the stretched bus sequencer
`timescale 1ns/1ps
module sedb_chk (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rstn,
  // Observed ports
  input wire i_req,
  input wire o_ready,
  input wire [2:0] o_stretch_code,
  input wire o_ad_oe_n,
  input wire o_ad_weak,
  input wire o_ale,
  input wire o_rd_n,
  input wire o_wr_n
);
  wire tk = i_req && o_ready;
  wire st = o_rd_n && o_wr_n;
  wire un = o_stretch_code == 3'h0;
  reg [5:0] lc;
  reg [2:0] cd;
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lc <= 6'h0;
      cd <= 3'h0;
    end else begin
      lc <= st ? 6'h0 : lc + 6'h1;
      if (tk) cd <= o_stretch_code;
    end
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  ale_unstr_a: assert property (tk && un |=> !o_ale ##1 o_ale [*3] ##1 !o_ale)
    else $error("latch strobe width unstretched");
  ale_str_a: assert property (tk && !un |=> !o_ale ##1 o_ale [*4] ##1 !o_ale)
    else $error("latch strobe width stretched");
  strb_unstr_a: assert property (tk && un |=> ##4 st ##1 !st [*4] ##1 st)
    else $error("strobe placement unstretched");
  strb_str_a: assert property (tk && !un |=> ##6 st ##1 !st)
    else $error("strobe placement stretched");
  strb_len_a: assert property ($rose(st) |-> lc == (cd == 3'h0 ? 6'h4 : {cd, 3'h0}))
    else $error("strobe low length");
  whold_unstr_a: assert property ($rose(o_wr_n) && cd == 3'h0 |-> !o_ad_oe_n [*2] ##1 o_ad_oe_n)
    else $error("write data hold unstretched");
  whold_str_a: assert property ($rose(o_wr_n) && cd != 3'h0 |-> !o_ad_oe_n [*4] ##1 o_ad_oe_n)
    else $error("write data hold stretched");
  wdata_on_a: assert property (!o_wr_n |-> !o_ad_oe_n)
    else $error("write data not driven");
  weak_hold_a: assert property (o_ad_weak |-> o_ad_oe_n && !o_ale && st)
    else $error("weak hold out of place");
endmodule
bind sedb_bus sedb_chk u_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_req(i_req),
  .o_ready(o_ready), .o_stretch_code(o_stretch_code), .o_ad_oe_n(o_ad_oe_n),
  .o_ad_weak(o_ad_weak), .o_ale(o_ale), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n));

// ---- tb/sedb_mem.sv ----
// External memory model on the multiplexed port
`timescale 1ns/1ps
module sedb_mem (
  // Clock
  input wire i_core_clk,
  // Device pins
  input wire [7:0] i_ad_out,
  input wire i_ad_oe_n,
  input wire i_ad_weak,
  input wire [7:0] i_addr_hi,
  input wire i_ale,
  input wire i_rd_n,
  input wire i_wr_n,
  input wire i_slow,
  // Port level
  output logic [7:0] o_ad
);
  logic [7:0] mem [0:65535];
  logic [15:0] adr;
  logic [7:0] last;
  logic pale;
  int lowc;
  always @(posedge i_core_clk) begin
    pale <= i_ale;
    if (pale && !i_ale) adr <= {i_addr_hi, o_ad};
    if (!i_wr_n) mem[adr] <= o_ad;
    lowc <= i_rd_n ? 0 : lowc + 1;
    if (!i_ad_oe_n) last <= i_ad_out;
  end
  always @* begin
    if (!i_ad_oe_n) o_ad = i_ad_out;
    else if (i_ad_weak) o_ad = last;
    else if (!i_rd_n && !(i_slow && lowc < 3)) o_ad = mem[adr];
    else o_ad = ~last;
  end
endmodule

// ---- tb/tb_stretched_external_data_bus.sv ----
// Testbench for the stretched external data bus
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_stretched_external_data_bus;
  logic i_core_clk = 0, i_rstn = 0, i_stretch_load = 0, i_req = 0, i_write = 0, slow = 0;
  logic [2:0] sel = 3'h0;
  logic [15:0] i_addr = 16'h0;
  logic [7:0] i_wdata = 8'h0;
  wire o_ready, o_done, o_ad_oe_n, o_ad_weak, o_ale, o_rd_n, o_wr_n;
  wire [7:0] o_rdata, o_ad_out, o_addr_hi, ad;
  wire [2:0] o_stretch_code;
  int error_cnt = 0, samples_checked = 0;
  always #25 i_core_clk = ~i_core_clk;
  sedb_bus dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_stretch_load(i_stretch_load),
    .i_stretch_sel_bit2(sel[2]), .i_stretch_sel_bit1(sel[1]), .i_stretch_sel_bit0(sel[0]),
    .i_req(i_req), .i_write(i_write), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready),
    .o_done(o_done), .o_rdata(o_rdata), .o_stretch_code(o_stretch_code), .i_ad_in(ad),
    .o_ad_out(o_ad_out), .o_ad_oe_n(o_ad_oe_n), .o_ad_weak(o_ad_weak), .o_addr_hi(o_addr_hi),
    .o_ale(o_ale), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n));
  sedb_mem u_mem (.i_core_clk(i_core_clk), .i_ad_out(o_ad_out), .i_ad_oe_n(o_ad_oe_n),
    .i_ad_weak(o_ad_weak), .i_addr_hi(o_addr_hi), .i_ale(o_ale), .i_rd_n(o_rd_n),
    .i_wr_n(o_wr_n), .i_slow(slow), .o_ad(ad));
  task end_of_test;
    $display("Errors %0d of %0d checks", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task xfer(input logic w, input logic [15:0] a, input logic [7:0] d, input int len);
    int n;
    n = 0;
    while (o_ready !== 1'b1) begin
      @(negedge i_core_clk);
      n++;
      if (n > 200) begin
        error_cnt++;
        end_of_test;
      end
    end
    i_req = 1;
    i_write = w;
    i_addr = a;
    i_wdata = d;
    @(negedge i_core_clk);
    i_req = 0;
    n = 1;
    while (o_done !== 1'b1 && n < 100) begin
      @(negedge i_core_clk);
      n++;
    end
    `CHK("length", len + 1, n)
    if (n >= 100) end_of_test;
  endtask
  task load(input logic [2:0] c);
    sel = c;
    i_stretch_load = 1;
    @(negedge i_core_clk);
    i_stretch_load = 0;
    @(negedge i_core_clk);
    `CHK("code", c, o_stretch_code)
  endtask
  task t_reset;
    `CHK("reset code", 3'h1, o_stretch_code)
    `CHK("reset strobes", 3'h3, {o_ale, o_rd_n, o_wr_n})
  endtask
  task t_default;
    xfer(1'b1, 16'h3a5c, 8'hc3, 24);
    xfer(1'b0, 16'h3a5c, 8'h00, 24);
    `CHK("rdata", 8'hc3, o_rdata)
  endtask
  task t_codes;
    for (int c = 0; c < 8; c++) begin
      load(c[2:0]);
      slow = c[0];
      xfer(1'b1, {c[7:0] + 8'h81, 8'h18 + c[7:0]}, 8'h96 ^ c[7:0], (c + 2) * 8);
      xfer(1'b0, {c[7:0] + 8'h81, 8'h18 + c[7:0]}, 8'h00, (c + 2) * 8);
      `CHK("rdata", 8'h96 ^ c[7:0], o_rdata)
    end
  endtask
  initial begin
    repeat (5) @(negedge i_core_clk);
    t_reset;
    i_rstn = 1;
    @(negedge i_core_clk);
    t_default;
    t_codes;
    end_of_test;
  end
endmodule
